// File: logic/rwc_cfg.svh
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH

// ****************************************************************
// clock and count source
// ****************************************************************
`define RWC_MCLK_HZ      10000000
`define RWC_SRC_HZ       4000

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define RWC_IDX_WEEKDAY  10'h11b
`define RWC_IDX_CONTROL  10'h11c
`define RWC_IDX_IRQEN    10'h11d
`define RWC_ADDR_SPAN_W  12

// ****************************************************************
// field positions
// ****************************************************************
`define RWC_WK_BUSY      7
`define RWC_CR_RUNCMD    7
`define RWC_CR_H24       6
`define RWC_CR_PM        5
`define RWC_CR_CLR       4
`define RWC_CR_IRQT      3
`define RWC_CR_RSVD      2
`define RWC_CR_STATUS    1
`define RWC_IE_SEC       0
`define RWC_IE_MIN       1
`define RWC_IE_HOUR      2
`define RWC_IE_DAY       3
`define RWC_IE_WEEK      4

// ****************************************************************
// values
// ****************************************************************
`define RWC_DAY_SUN      3'h0
`define RWC_DAY_SAT      3'h6
`define RWC_IE_MASK      8'h3f
`define RWC_CNT4_LAST    4'hf
`define RWC_CNT8_LAST    8'h7f
`define RWC_BUSY_START   8'h78
`define RWC_HTRANS_BUSY  1

`endif

// File: logic/rwc_pkg.sv
package rwc_pkg;

	// ****************************************************************
	// register select
	// ****************************************************************
	typedef enum logic [1:0] {
		RWC_SEL_NONE    = 2'b00,
		RWC_SEL_WEEKDAY = 2'b01,
		RWC_SEL_CONTROL = 2'b10,
		RWC_SEL_IRQEN   = 2'b11
	} rwc_sel_e;

endpackage : rwc_pkg

// File: logic/rwc_weekday_ctrl.sv
// Function
// [RULE1] day field is bits 2:0 of the weekday register, 000 Sunday to 110 Saturday, one step per day.
// [RULE2] software never writes 111 into the day field.
// [RULE3] weekday bit 7 is a read-only busy flag, 1 while time registers are updating.
// [RULE4] unassigned bits of weekday, control and irq-enable read as 0; the code reads back control bit 2 and irq-enable bit 5 as written.
// [RULE5] control bit 1 is read-only run status: 0 stopped, 1 counting.
// [RULE6] control bit 7 is the run command: 1 starts counting, 0 stops it.
// [RULE7] control bit 6 selects 12-hour (0) or 24-hour (1) operation.
// [RULE8] control bit 5 is the p.m. flag, toggled automatically in 12-hour mode while counting.
// [RULE9] software sets control bit 3, the irq timing bit, to 1 in clock use.
// [RULE10] writing 1 then 0 to control bit 4 clears weekday, irq-enable and the control fields.
// [RULE11] that clear sequence also zeroes the 8-bit and 4-bit prescale counters.
// [RULE12] irq-enable bits 0 to 4 enable second, minute, hour, day and week interrupts.
// [RULE13] week irq fires when the day becomes Sunday; day, hour, minute, second on their updates.
// [RULE14] software enables at most one periodic source at a time.
// [RULE15] run status follows the run command within two count-source cycles.
// [RULE16] a day carry at Saturday wraps the field to Sunday.
`include "rwc_cfg.svh"

module rwc_weekday_ctrl #(
	parameter int SRC_DIV = `RWC_MCLK_HZ / `RWC_SRC_HZ,
	parameter int ADDR_W  = 12
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire logic              minuteUpdate,
	input  wire logic              hourUpdate,
	input  wire logic              dayCarry,
	input  wire logic              noonCross,
	input  wire logic              hmsBusy,
	output logic                   secondTick,
	output logic                   countRunning,
	output logic                   hourFormat24,
	output logic                   irqTimingSel,
	output logic                   softClearPulse,
	output logic                   periodicIrq
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (SRC_DIV < 2 || SRC_DIV > 65536) begin : g_bad_div
		$error("SRC_DIV out of range");
	end
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W out of range");
	end

	localparam logic [15:0] SRC_LAST = 16'(SRC_DIV - 1);
	localparam int          LAG_MAX  = 2 * SRC_DIV + 2;

	typedef struct packed {
		logic [15:0]       srcCnt;
		logic              div2;
		logic [3:0]        cnt4;
		logic [7:0]        cnt8;
		logic              runStage;
		logic              runStatus;
		logic              runCmd;
		logic              hour24;
		logic              afternoon;
		logic              softClr;
		logic              irqTiming;
		logic              rsvd2;
		logic [2:0]        day;
		logic [5:0]        irqEn;
		logic              dpValid;
		logic              dpWrite;
		rwc_pkg::rwc_sel_e dpSel;
		logic              rdReady;
		logic [7:0]        rdata;
		logic              secTick;
		logic              clrPulse;
		logic              irq;
	} rwc_state_s;

	rwc_state_s q;
	rwc_state_s d;

	// ****************************************************************
	// address decode
	// ****************************************************************
	function automatic rwc_pkg::rwc_sel_e decodeSel(
		input logic [ADDR_W-1:0] addr
	);
		logic [9:0] idx;
		idx = addr[11:2];
		if ((addr >> `RWC_ADDR_SPAN_W) != '0)
			decodeSel = rwc_pkg::RWC_SEL_NONE;
		else if (idx == `RWC_IDX_WEEKDAY)
			decodeSel = rwc_pkg::RWC_SEL_WEEKDAY;
		else if (idx == `RWC_IDX_CONTROL)
			decodeSel = rwc_pkg::RWC_SEL_CONTROL;
		else if (idx == `RWC_IDX_IRQEN)
			decodeSel = rwc_pkg::RWC_SEL_IRQEN;
		else
			decodeSel = rwc_pkg::RWC_SEL_NONE;
	endfunction

	logic       srcTick;
	logic       busy;
	logic       accept;
	logic       rdStall;
	logic       wrStrobe;
	logic       clearAll;
	logic       dayUpd;
	logic [2:0] nextDay;
	logic [7:0] wdat;
	logic [7:0] rdMux;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		wdat = hwdata[7:0];
		srcTick = (q.srcCnt == SRC_LAST);
		// busy covers the final stretch before a second rolls over
		busy = hmsBusy | (q.runStatus && q.cnt8 >= `RWC_BUSY_START); // see [RULE3]
		accept = hsel & htrans[`RWC_HTRANS_BUSY] & hready;
		rdStall = q.dpValid & ~q.dpWrite & ~q.rdReady;
		wrStrobe = q.dpValid & q.dpWrite;
		clearAll = wrStrobe && q.dpSel == rwc_pkg::RWC_SEL_CONTROL
			&& q.softClr && !wdat[`RWC_CR_CLR]; // see [RULE10]
		dayUpd = dayCarry & q.runStatus;
		// saturday wraps so the forbidden code is never produced
		nextDay = (q.day == `RWC_DAY_SAT) ? `RWC_DAY_SUN
			: 3'(q.day + 3'h1); // see [RULE1] see [RULE16]

		case (q.dpSel)
			rwc_pkg::RWC_SEL_WEEKDAY: begin
				rdMux = 8'h00;
				rdMux[2:0] = q.day;
				rdMux[`RWC_WK_BUSY] = busy; // see [RULE3] see [RULE4]
			end
			rwc_pkg::RWC_SEL_CONTROL: begin
				rdMux = 8'h00; // see [RULE4]
				rdMux[`RWC_CR_RUNCMD] = q.runCmd;
				rdMux[`RWC_CR_H24] = q.hour24;
				rdMux[`RWC_CR_PM] = q.afternoon;
				rdMux[`RWC_CR_CLR] = q.softClr;
				rdMux[`RWC_CR_IRQT] = q.irqTiming;
				rdMux[`RWC_CR_RSVD] = q.rsvd2;
				rdMux[`RWC_CR_STATUS] = q.runStatus; // see [RULE5]
			end
			rwc_pkg::RWC_SEL_IRQEN: begin
				rdMux = {2'h0, q.irqEn}; // see [RULE4]
			end
			default: begin
				rdMux = 8'h00;
			end
		endcase

		// count source and run synchroniser: two source ticks at most
		d.srcCnt = srcTick ? 16'h0000 : 16'(q.srcCnt + 16'h0001);
		if (srcTick) begin
			d.runStage = q.runCmd; // see [RULE6] see [RULE15]
			d.runStatus = q.runStage; // see [RULE15]
			if (q.runStatus) begin
				d.div2 = ~q.div2;
				if (q.div2) begin
					d.cnt4 = 4'(q.cnt4 + 4'h1);
					if (q.cnt4 == `RWC_CNT4_LAST)
						d.cnt8 = (q.cnt8 == `RWC_CNT8_LAST) ? 8'h00
							: 8'(q.cnt8 + 8'h01);
				end
			end
		end
		d.secTick = srcTick & q.runStatus & q.div2
			& (q.cnt4 == `RWC_CNT4_LAST) & (q.cnt8 == `RWC_CNT8_LAST);

		if (dayUpd)
			d.day = nextDay; // see [RULE1]
		if (noonCross && q.runStatus && !q.hour24)
			d.afternoon = ~q.afternoon; // see [RULE8]

		// periodic request, one pulse per cycle with an enabled update
		d.irq = (q.secTick & q.irqEn[`RWC_IE_SEC])
			| (minuteUpdate & q.irqEn[`RWC_IE_MIN])
			| (hourUpdate & q.irqEn[`RWC_IE_HOUR])
			| (dayUpd & q.irqEn[`RWC_IE_DAY])
			| (dayUpd && nextDay == `RWC_DAY_SUN
				&& q.irqEn[`RWC_IE_WEEK]); // see [RULE12] see [RULE13]

		// bus: reads take one wait state so hrdata comes from a flop
		d.dpValid = accept | rdStall;
		if (accept) begin
			d.dpWrite = hwrite;
			d.dpSel = decodeSel(haddr);
		end
		d.rdReady = rdStall;
		if (rdStall)
			d.rdata = rdMux;

		if (wrStrobe) begin
			case (q.dpSel)
				rwc_pkg::RWC_SEL_WEEKDAY: begin
					d.day = wdat[2:0]; // see [RULE1]
				end
				rwc_pkg::RWC_SEL_CONTROL: begin
					d.runCmd = wdat[`RWC_CR_RUNCMD]; // see [RULE6]
					d.hour24 = wdat[`RWC_CR_H24]; // see [RULE7]
					d.afternoon = wdat[`RWC_CR_PM];
					d.softClr = wdat[`RWC_CR_CLR];
					d.irqTiming = wdat[`RWC_CR_IRQT];
					d.rsvd2 = wdat[`RWC_CR_RSVD];
				end
				rwc_pkg::RWC_SEL_IRQEN: begin
					d.irqEn = 6'(wdat & `RWC_IE_MASK); // see [RULE12]
				end
				default: begin
				end
			endcase
		end

		d.clrPulse = clearAll;
		if (clearAll) begin
			d.day = `RWC_DAY_SUN; // see [RULE10]
			d.irqEn = 6'h00;
			d.runStatus = 1'b0;
			d.runStage = 1'b0;
			d.irqTiming = 1'b0;
			d.afternoon = 1'b0;
			d.hour24 = 1'b0;
			d.runCmd = 1'b0;
			d.cnt8 = 8'h00; // see [RULE11]
			d.cnt4 = 4'h0;
			d.div2 = 1'b0;
			d.secTick = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign hreadyout = ~rdStall;
	assign hresp = 1'b0;
	assign hrdata = {24'h000000, q.rdata};
	assign secondTick = q.secTick;
	assign countRunning = q.runStatus; // see [RULE5]
	assign hourFormat24 = q.hour24; // see [RULE7]
	assign irqTimingSel = q.irqTiming;
	assign softClearPulse = q.clrPulse; // see [RULE10]
	assign periodicIrq = q.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	int lagCnt;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			lagCnt <= 0;
		else if (q.runStatus == q.runCmd)
			lagCnt <= 0;
		else
			lagCnt <= lagCnt + 1;
	end

	AST_RUN_LAG: assert property ( // see [RULE15]
		@(posedge mclk) disable iff (!rst_n) lagCnt <= LAG_MAX)
		else $error("run status lags run command too long");

	AST_SAT_WRAP: assert property ( // see [RULE16]
		@(posedge mclk) disable iff (!rst_n)
		(dayCarry && q.runStatus && q.day == `RWC_DAY_SAT && !wrStrobe
			&& !clearAll) |=> q.day == `RWC_DAY_SUN)
		else $error("saturday did not wrap to sunday");

	AST_DAY_STEP: assert property ( // see [RULE1]
		@(posedge mclk) disable iff (!rst_n)
		(dayUpd && q.day < `RWC_DAY_SAT && !wrStrobe && !clearAll)
			|=> q.day == 3'($past(q.day) + 3'h1))
		else $error("day did not advance by one");

	AST_DAY_HOLD: assert property ( // see [RULE1]
		@(posedge mclk) disable iff (!rst_n)
		(dayCarry && !q.runStatus && !wrStrobe && !clearAll)
			|=> q.day == $past(q.day))
		else $error("day moved while stopped");

	AST_BUSY_FLAG: assert property ( // see [RULE3]
		@(posedge mclk) disable iff (!rst_n)
		(rdStall && q.dpSel == rwc_pkg::RWC_SEL_WEEKDAY && hmsBusy)
			|=> hrdata[`RWC_WK_BUSY])
		else $error("busy flag not read as set");

	AST_RSVD_ZERO: assert property ( // see [RULE4]
		@(posedge mclk) disable iff (!rst_n)
		(q.rdReady && q.dpSel == rwc_pkg::RWC_SEL_WEEKDAY)
			|-> hrdata[6:3] == 4'h0)
		else $error("weekday reserved bits not zero");

	AST_STATUS_READ: assert property ( // see [RULE5]
		@(posedge mclk) disable iff (!rst_n)
		(rdStall && q.dpSel == rwc_pkg::RWC_SEL_CONTROL)
			|=> hrdata[`RWC_CR_STATUS] == $past(q.runStatus)
			&& hrdata[0] == 1'b0)
		else $error("status bit read wrong");

	AST_SOFT_CLEAR: assert property ( // see [RULE10] see [RULE11]
		@(posedge mclk) disable iff (!rst_n)
		clearAll |=> q.day == `RWC_DAY_SUN && q.irqEn == 6'h00
			&& q.cnt8 == 8'h00 && q.cnt4 == 4'h0 && !q.runCmd
			&& !q.runStatus && !q.hour24 && softClearPulse)
		else $error("soft clear incomplete");

	AST_WEEK_IRQ: assert property ( // see [RULE13]
		@(posedge mclk) disable iff (!rst_n)
		(dayUpd && nextDay == `RWC_DAY_SUN && q.irqEn[`RWC_IE_WEEK])
			|=> periodicIrq)
		else $error("week interrupt missing");

	AST_SEC_IRQ: assert property ( // see [RULE12]
		@(posedge mclk) disable iff (!rst_n)
		(q.secTick && q.irqEn[`RWC_IE_SEC]) |=> periodicIrq)
		else $error("second interrupt missing");

	AST_NO_IRQ: assert property ( // see [RULE12]
		@(posedge mclk) disable iff (!rst_n)
		(q.irqEn == 6'h00) |=> !periodicIrq)
		else $error("interrupt while all disabled");

	AST_PM_TOGGLE: assert property ( // see [RULE8]
		@(posedge mclk) disable iff (!rst_n)
		(noonCross && q.runStatus && !q.hour24 && !wrStrobe && !clearAll)
			|=> q.afternoon != $past(q.afternoon))
		else $error("pm flag did not toggle");

	AST_READ_WAIT: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(accept && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

endmodule // rwc_weekday_ctrl

// File: testbench/tb_rwc_weekday_ctrl.sv
module tb_rwc_weekday_ctrl;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// signals
	// ****************************************************************
	// short divider keeps one second at 8192 clocks
	localparam int          DIV     = 2;
	localparam int          SEC_CYC = 2 * 16 * 128 * DIV;
	localparam logic [11:0] A_WK    = 12'h46c;
	localparam logic [11:0] A_CR    = 12'h470;
	localparam logic [11:0] A_IE    = 12'h474;

	logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, d;
	logic        minuteUpdate, hourUpdate, dayCarry, noonCross, hmsBusy;
	logic        secondTick, countRunning, hourFormat24, irqTimingSel;
	logic        softClearPulse, periodicIrq;
	int          mismatches = 0, check_count = 0, cyc = 0;
	int          irqCount = 0, clrCount = 0, n, i;
	logic [7:0]  en [4] = '{8'h10, 8'h08, 8'h04, 8'h02};
	int          ev [4] = '{3, 3, 2, 1};

	rwc_weekday_ctrl #(.SRC_DIV(DIV), .ADDR_W(12)) rwc_weekday_ctrl_i (
		.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .minuteUpdate(minuteUpdate),
		.hourUpdate(hourUpdate), .dayCarry(dayCarry),
		.noonCross(noonCross), .hmsBusy(hmsBusy),
		.secondTick(secondTick), .countRunning(countRunning),
		.hourFormat24(hourFormat24), .irqTimingSel(irqTimingSel),
		.softClearPulse(softClearPulse), .periodicIrq(periodicIrq)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// pulses are one cycle wide, so count them where they occur
	always @(posedge mclk) begin
		cyc++;
		if (periodicIrq === 1'b1)
			irqCount++;
		if (softClearPulse === 1'b1)
			clrCount++;
		if (cyc == 40000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [11:0] a,
			input logic [7:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		bus(1'b0, a, 8'h00, v);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		logic [31:0] dummy;
		bus(1'b1, a, v, dummy);
	endtask

	task automatic evt(input int k);
		@(posedge mclk);
		case (k)
			1: minuteUpdate <= 1'b1;
			2: hourUpdate <= 1'b1;
			5: noonCross <= 1'b1;
			default: dayCarry <= 1'b1;
		endcase
		@(posedge mclk);
		minuteUpdate <= 1'b0;
		hourUpdate <= 1'b0;
		dayCarry <= 1'b0;
		noonCross <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic waitTick(output int t);
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (secondTick !== 1'b1);
	endtask

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		hmsBusy = 1'b0;
		minuteUpdate = 1'b0;
		hourUpdate = 1'b0;
		dayCarry = 1'b0;
		noonCross = 1'b0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		rd(A_WK, d);
		chk("weekday reset", 32'h0, d);
		rd(A_CR, d);
		chk("control reset", 32'h0, d);
		rd(A_IE, d);
		chk("irq enable reset", 32'h0, d);
		rd(12'h478, d);
		chk("unmapped", 32'h0, d);
		$display("test reset done");
		// upper bits set on purpose: weekday bits 6:3 and irq-enable bits 7:6 must read back 0
		wr(A_WK, 8'hfe);
		rd(A_WK, d);
		chk("day", 32'h06, d);
		wr(A_IE, 8'hf0);
		rd(A_IE, d);
		chk("irq en", 32'h30, d);
		wr(A_CR, 8'h4c);
		rd(A_CR, d);
		chk("control", 32'h4c, d);
		chk("24h out", 32'h1, {31'h0, hourFormat24});
		chk("irq timing", 32'h1, {31'h0, irqTimingSel});
		wr(A_CR, 8'h88);
		n = 0;
		while (countRunning !== 1'b1 && n < 2 * DIV + 2) begin
			@(posedge mclk);
			n++;
		end
		chk("run status", 32'h1, {31'h0, countRunning});
		rd(A_CR, d);
		chk("control run", 32'h8a, d);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			wr(A_IE, en[i]);
			n = irqCount;
			evt(ev[i]);
			chk("irq per event", n + 1, irqCount);
		end
		rd(A_WK, d);
		chk("day wrap", 32'h1, d & 32'h7);
		wr(A_IE, 8'h10);
		n = irqCount;
		evt(3);
		chk("no week irq", n, irqCount);
		evt(5);
		rd(A_CR, d);
		chk("pm flag", 32'haa, d);
		hmsBusy <= 1'b1;
		rd(A_WK, d);
		chk("busy", 32'h1, {31'h0, d[7]});
		hmsBusy <= 1'b0;
		wr(A_IE, 8'h01);
		waitTick(n);
		@(posedge mclk);
		chk("second irq", 32'h1, {31'h0, periodicIrq});
		$display("test events done");
		// park the prescaler mid-second so a missed clear shows
		repeat (4000) @(posedge mclk);
		n = clrCount;
		wr(A_CR, 8'h98);
		wr(A_CR, 8'h00);
		repeat (3) @(posedge mclk);
		chk("clear pulse", n + 1, clrCount);
		// a day carry while stopped must leave the day alone
		evt(3);
		rd(A_WK, d);
		chk("weekday clr", 32'h0, d);
		rd(A_IE, d);
		chk("irq en clr", 32'h0, d);
		rd(A_CR, d);
		chk("control clr", 32'h0, d);
		wr(A_CR, 8'h88);
		waitTick(n);
		chk("full second", 32'h1,
			{31'h0, n > SEC_CYC - 100 && n < SEC_CYC + 100});
		$display("test soft clear done");
		end_of_test();
	end

endmodule // tb_rwc_weekday_ctrl
